// ===== common/crf_pkg.sv
// Overview of operation
// - Responses leave serially on the command line, MSB first, length fixed by type.
// - Every response opens with start bit 0, then direction bit 0.
// - Every response closes with end bit 1.
// - Seven-bit checksum in bits 7..1 of status and published-address responses only.
// - Status response is 48 bits: command index 45..40, status word 39..8.
// - Card may hold data line busy after each written block; host tests it.
// - Busy-variant status response matches status format; busy may follow on data line.
// - Long response is 136 bits: 111111 in 133..128, register bits 127..1.
// - Identity register for identity broadcast/read; specific data for specific-data read.
// - Register bit 0 is never sent; the end bit takes its place.
// - Operating-condition response: 111111, condition register 39..8, 1111111 in 7..1.
// - Only status, long, operating-condition and published-address formats exist.
// - Published-address argument upper 16 bits carry new relative card address.
// - Lower 16 bits carry status bits 23, 22, 19 and 12..0.
// - Idle query: compatible to ready, busy stays idle, incompatible to inactive.
// - Command and response bits launch on the bus clock rising edge.
// - Command line stays undriven two bit periods before the response.
package crf_pkg;
	localparam int CRF_FRAME_W = 136;
	localparam int CRF_PAD_W = 88;
	localparam int CRF_REG_W = 128;
	localparam logic [7:0] CRF_SHORT_LEN = 8'd48;
	localparam logic [7:0] CRF_LONG_LEN = 8'd136;
	localparam logic [7:0] CRF_LAST_SHORT = CRF_SHORT_LEN - 8'd1;
	localparam logic [7:0] CRF_LAST_LONG = CRF_LONG_LEN - 8'd1;
	localparam logic [7:0] CRF_CRC_FIRST = 8'd40;
	localparam logic [7:0] CRF_CRC_LAST = 8'd46;
	localparam logic [7:0] CRF_IDX_FIRST = 8'd2;
	localparam logic [7:0] CRF_IDX_LAST = 8'd7;
	localparam logic [7:0] CRF_TURN_LAST = 8'd1;
	localparam logic CRF_START_BIT = 1'b0;
	localparam logic CRF_DIR_CARD = 1'b0;
	localparam logic CRF_END_BIT = 1'b1;
	localparam logic [6:0] CRF_CRC_POLY = 7'h09;
	localparam logic [6:0] CRF_CRC_INIT = 7'h00;
	localparam logic [6:0] CRF_RSV_CRC = 7'h7F;
	localparam logic [5:0] CRF_RSV_IDX = 6'h3F;
	localparam logic [5:0] CRF_ADDR_PUB_IDX = 6'h03;
	localparam logic [5:0] CRF_CMD_ID_BCAST = 6'h02;
	localparam logic [5:0] CRF_CMD_ADDR_PUB = 6'h03;
	localparam logic [5:0] CRF_CMD_SPEC_RD = 6'h09;
	localparam logic [5:0] CRF_CMD_ID_RD = 6'h0A;
	localparam logic [5:0] CRF_CMD_OPCOND = 6'h29;
	localparam int CRF_ST_A = 23;
	localparam int CRF_ST_B = 22;
	localparam int CRF_ST_C = 19;
	localparam int CRF_ST_LOW = 12;
	typedef enum logic [2:0] {CRF_IDLE, CRF_READY, CRF_IDENT, CRF_STBY, CRF_INACTIVE} crf_state_t;
	typedef enum logic [1:0] {CRF_R_STATUS, CRF_R_LONG, CRF_R_OPCOND, CRF_R_ADDR} crf_resp_t;
	typedef enum logic [1:0] {CRF_L_IDLE, CRF_L_TURN, CRF_L_SEND} crf_link_t;
endpackage

// ===== src/crf_formatter.sv
`timescale 1ns/1ps
module crf_formatter
	import crf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic bus_clk,
	input wire logic cmd_strobe,
	input wire logic [5:0] cmd_index,
	input wire logic cmd_app,
	input wire logic cmd_defined,
	input wire logic vdd_ok,
	input wire logic power_busy,
	input wire logic block_busy,
	input wire logic [31:0] card_status,
	input wire logic [127:0] card_identity_register,
	input wire logic [127:0] card_specific_data_register,
	input wire logic [31:0] operating_conditions_register,
	input wire logic [15:0] relative_card_address,
	output logic cmd_out,
	output logic cmd_oe,
	output logic dat0_out,
	output logic dat0_oe,
	output crf_state_t card_state,
	output logic resp_pending
);

	function automatic logic crf_hit(input logic [5:0] idx, input logic app, input logic [5:0] want, input logic want_app);
		crf_hit = (idx == want) && (app == want_app);
	endfunction

	// Core side
	crf_state_t state_reg;
	crf_state_t state_next;
	crf_resp_t kind_reg;
	crf_resp_t kind_next;
	logic pend_reg;
	logic req_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic ack_seen_reg;
	logic busy_lvl_reg;
	logic ack_tgl_reg;
	logic [5:0] idx_reg;
	logic [5:0] idx_next;
	logic [31:0] arg_reg;
	logic [31:0] arg_next;
	logic [127:0] long_reg;
	logic [127:0] long_next;

	wire is_opq = crf_hit(cmd_index, cmd_app, CRF_CMD_OPCOND, 1'b1) && state_reg == CRF_IDLE;
	wire is_idb = crf_hit(cmd_index, cmd_app, CRF_CMD_ID_BCAST, 1'b0) && state_reg == CRF_READY;
	wire is_pub = crf_hit(cmd_index, cmd_app, CRF_CMD_ADDR_PUB, 1'b0) &&
		(state_reg == CRF_IDENT || state_reg == CRF_STBY);
	wire is_csd = crf_hit(cmd_index, cmd_app, CRF_CMD_SPEC_RD, 1'b0) && state_reg == CRF_STBY;
	wire is_cidr = crf_hit(cmd_index, cmd_app, CRF_CMD_ID_RD, 1'b0) && state_reg == CRF_STBY;
	wire is_special = is_opq || is_idb || is_pub || is_csd || is_cidr;
	wire respond = cmd_strobe && !pend_reg && (is_special || cmd_defined);
	wire ack_done = ack_s2_reg != ack_seen_reg;
	wire [15:0] short_status = {card_status[CRF_ST_A], card_status[CRF_ST_B], card_status[CRF_ST_C],
		card_status[CRF_ST_LOW:0]};

	always_comb begin
		state_next = state_reg;
		if (respond && is_opq) begin
			state_next = !vdd_ok ? CRF_INACTIVE : (power_busy ? CRF_IDLE : CRF_READY);
		end else if (respond && is_idb) begin
			state_next = CRF_IDENT;
		end else if (respond && is_pub) begin
			state_next = CRF_STBY;
		end
	end

	assign long_next = is_csd ? card_specific_data_register : card_identity_register;
	assign kind_next = is_opq ? CRF_R_OPCOND : (is_pub ? CRF_R_ADDR :
		((is_idb || is_csd || is_cidr) ? CRF_R_LONG : CRF_R_STATUS));
	assign idx_next = is_opq ? CRF_RSV_IDX : (is_pub ? CRF_ADDR_PUB_IDX : cmd_index);
	assign arg_next = is_opq ? operating_conditions_register :
		(is_pub ? {relative_card_address, short_status} : card_status);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_reg <= CRF_IDLE;
			busy_lvl_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			busy_lvl_reg <= block_busy;
		end
	end

	// Fields stay frozen while pending, so the link may sample them
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			kind_reg <= CRF_R_STATUS;
			idx_reg <= 6'h00;
			arg_reg <= 32'h0000_0000;
			long_reg <= '0;
		end else if (respond) begin
			kind_reg <= kind_next;
			idx_reg <= idx_next;
			arg_reg <= arg_next;
			long_reg <= long_next;
		end
	end

	// Set wins over the acknowledge clear
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pend_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
		end else begin
			pend_reg <= respond || (pend_reg && !ack_done);
			req_tgl_reg <= req_tgl_reg ^ respond;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_seen_reg <= ack_s2_reg;
		end
	end

	assign card_state = state_reg;
	assign resp_pending = pend_reg;

	// Link side
	crf_link_t lstate_reg;
	logic lrst_s1_reg;
	logic lrst_s2_reg;
	logic req_s1_reg;
	logic req_s2_reg;
	logic req_seen_reg;
	logic busy_s1_reg;
	logic busy_s2_reg;
	logic cmd_out_reg;
	logic cmd_oe_reg;
	logic dat0_oe_reg;
	logic dat0_out_reg;
	logic [7:0] cnt_reg;
	logic [7:0] last_reg;
	logic [6:0] crc_reg;
	logic [CRF_FRAME_W-1:0] sh_reg;

	wire lrst = !lrst_s2_reg;
	wire new_req = req_s2_reg != req_seen_reg;
	wire is_long = kind_reg == CRF_R_LONG;
	wire crc_on = kind_reg == CRF_R_STATUS || kind_reg == CRF_R_ADDR;
	wire crc_zone = cnt_reg >= CRF_CRC_FIRST && cnt_reg <= CRF_CRC_LAST;
	wire send_end = lstate_reg == CRF_L_SEND && cnt_reg == last_reg;
	wire bit_now = (crc_on && crc_zone) ? crc_reg[6] : sh_reg[CRF_FRAME_W-1];
	wire crc_fb = sh_reg[CRF_FRAME_W-1] ^ crc_reg[6];
	wire [6:0] crc_adv = crc_zone ? {crc_reg[5:0], 1'b0} :
		({crc_reg[5:0], 1'b0} ^ (crc_fb ? CRF_CRC_POLY : CRF_CRC_INIT));
	wire [6:0] crc_fill = kind_reg == CRF_R_OPCOND ? CRF_RSV_CRC : CRF_CRC_INIT;
	wire [CRF_FRAME_W-1:0] frame_long = {CRF_START_BIT, CRF_DIR_CARD, CRF_RSV_IDX,
		long_reg[CRF_REG_W-1:1], CRF_END_BIT};
	wire [CRF_FRAME_W-1:0] frame_short = {CRF_START_BIT, CRF_DIR_CARD, idx_reg, arg_reg, crc_fill,
		CRF_END_BIT, {CRF_PAD_W{1'b0}}};

	// Reset released into the link domain; the bus clock may be stopped
	always_ff @(posedge bus_clk) begin
		lrst_s1_reg <= rst_b;
		lrst_s2_reg <= lrst_s1_reg;
	end

	always_ff @(posedge bus_clk) begin
		if (lrst) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			busy_s1_reg <= busy_lvl_reg;
			busy_s2_reg <= busy_s1_reg;
		end
	end

	always_ff @(posedge bus_clk) begin
		if (lrst) begin
			lstate_reg <= CRF_L_IDLE;
			cnt_reg <= 8'h00;
			req_seen_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
		end else begin
			case (lstate_reg)
				CRF_L_IDLE: begin
					cnt_reg <= 8'h00;
					if (new_req) begin
						req_seen_reg <= req_s2_reg;
						lstate_reg <= CRF_L_TURN;
					end
				end
				CRF_L_TURN: begin
					cnt_reg <= cnt_reg == CRF_TURN_LAST ? 8'h00 : cnt_reg + 8'h01;
					if (cnt_reg == CRF_TURN_LAST) begin
						lstate_reg <= CRF_L_SEND;
					end
				end
				CRF_L_SEND: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (send_end) begin
						ack_tgl_reg <= ~ack_tgl_reg;
						lstate_reg <= CRF_L_IDLE;
					end
				end
				default: begin
					lstate_reg <= CRF_L_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge bus_clk) begin
		if (lrst) begin
			sh_reg <= '0;
			crc_reg <= CRF_CRC_INIT;
			last_reg <= CRF_LAST_SHORT;
		end else if (lstate_reg == CRF_L_IDLE && new_req) begin
			sh_reg <= is_long ? frame_long : frame_short;
			crc_reg <= CRF_CRC_INIT;
			last_reg <= is_long ? CRF_LAST_LONG : CRF_LAST_SHORT;
		end else if (lstate_reg == CRF_L_SEND) begin
			sh_reg <= {sh_reg[CRF_FRAME_W-2:0], 1'b0};
			crc_reg <= crc_adv;
		end
	end

	always_ff @(posedge bus_clk) begin
		if (lrst) begin
			cmd_out_reg <= CRF_END_BIT;
			cmd_oe_reg <= 1'b0;
			dat0_out_reg <= 1'b0;
			dat0_oe_reg <= 1'b0;
		end else begin
			cmd_out_reg <= lstate_reg == CRF_L_SEND ? bit_now : CRF_END_BIT;
			cmd_oe_reg <= lstate_reg == CRF_L_SEND;
			dat0_out_reg <= 1'b0;
			// busy holds data low, never while the response is being sent
			dat0_oe_reg <= busy_s2_reg && lstate_reg != CRF_L_SEND;
		end
	end

	assign cmd_out = cmd_out_reg;
	assign cmd_oe = cmd_oe_reg;
	assign dat0_out = dat0_out_reg;
	assign dat0_oe = dat0_oe_reg;

	// Checking helpers
	logic [7:0] oe_run_reg;
	always_ff @(posedge bus_clk) begin
		if (lrst) begin
			oe_run_reg <= 8'h00;
		end else begin
			oe_run_reg <= cmd_oe_reg ? oe_run_reg + 8'h01 : 8'h00;
		end
	end

	sequence crf_lead_s;
		!cmd_out_reg ##1 !cmd_out_reg;
	endsequence

	start_dir_bits_a: assert property (@(posedge bus_clk) disable iff (lrst)
		$rose(cmd_oe_reg) |-> crf_lead_s)
		else $error("response lead bits not zero");
	end_bit_one_a: assert property (@(posedge bus_clk) disable iff (lrst)
		$fell(cmd_oe_reg) |-> $past(cmd_out_reg))
		else $error("response end bit not one");
	frame_length_a: assert property (@(posedge bus_clk) disable iff (lrst)
		$fell(cmd_oe_reg) |-> (oe_run_reg == CRF_SHORT_LEN || oe_run_reg == CRF_LONG_LEN))
		else $error("response length wrong");
	turn_gap_a: assert property (@(posedge bus_clk) disable iff (lrst)
		$rose(cmd_oe_reg) |-> !$past(cmd_oe_reg, 2) && !$past(cmd_oe_reg, 3))
		else $error("line driven too soon after command");
	opcond_ones_a: assert property (@(posedge bus_clk) disable iff (lrst)
		lstate_reg == CRF_L_SEND && kind_reg == CRF_R_OPCOND && crc_zone |=> cmd_out_reg)
		else $error("operating condition reserved bits not one");
	long_ones_a: assert property (@(posedge bus_clk) disable iff (lrst)
		lstate_reg == CRF_L_SEND && is_long && cnt_reg >= CRF_IDX_FIRST && cnt_reg <= CRF_IDX_LAST
		|=> cmd_out_reg)
		else $error("long response reserved bits not one");
	opq_state_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && is_opq |=> state_reg == ($past(vdd_ok) ? ($past(power_busy) ? CRF_IDLE : CRF_READY)
		: CRF_INACTIVE))
		else $error("query state outcome wrong");
	ignored_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		cmd_strobe && !respond |=> $stable(state_reg) && !$rose(pend_reg))
		else $error("ignored command changed card");
	addr_fields_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && is_pub |=> idx_reg == CRF_ADDR_PUB_IDX && arg_reg[31:16] == $past(relative_card_address))
		else $error("published address fields wrong");
	short_status_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && is_pub |=> arg_reg[15:0] == {$past(card_status[CRF_ST_A]), $past(card_status[CRF_ST_B]),
		$past(card_status[CRF_ST_C]), $past(card_status[CRF_ST_LOW:0])})
		else $error("compressed status wrong");
	status_fields_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && !is_special |=> kind_reg == CRF_R_STATUS && idx_reg == $past(cmd_index) &&
		arg_reg == $past(card_status))
		else $error("status response fields wrong");
	opcond_fields_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && is_opq |=> kind_reg == CRF_R_OPCOND && idx_reg == CRF_RSV_IDX &&
		arg_reg == $past(operating_conditions_register))
		else $error("operating condition fields wrong");
	data_select_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && is_csd |=> kind_reg == CRF_R_LONG && long_reg == $past(card_specific_data_register))
		else $error("specific data register not selected");
	ident_select_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		respond && (is_idb || is_cidr) |=> kind_reg == CRF_R_LONG && long_reg == $past(card_identity_register))
		else $error("identity register not selected");

	// Three quiet samples: load edge plus the two turnaround bits
	sequence crf_quiet_s;
		!cmd_oe_reg ##1 !cmd_oe_reg ##1 !cmd_oe_reg;
	endsequence

	turn_quiet_a: assert property (@(posedge bus_clk) disable iff (lrst)
		lstate_reg == CRF_L_IDLE && new_req |=> crf_quiet_s ##1 cmd_oe_reg)
		else $error("turnaround gap wrong");
	busy_shown_a: assert property (@(posedge bus_clk) disable iff (lrst)
		busy_s2_reg && lstate_reg != CRF_L_SEND |=> dat0_oe_reg && !dat0_out_reg)
		else $error("busy not shown on data line");

endmodule

// ===== test/crf_host_model.sv
`timescale 1ns/1ps
module crf_host_model (
	input wire logic run,
	input wire logic cmd_out,
	input wire logic cmd_oe,
	output logic bus_clk,
	output logic [135:0] frame,
	output int nbits
);
	logic cmd_line;
	logic oe_prev;
	assign cmd_line = cmd_oe ? cmd_out : 1'b1;
	// Clock stands still while run is low
	initial begin
		bus_clk = 1'b0;
		frame = '0;
		nbits = 0;
		oe_prev = 1'b0;
		#3;
		forever begin
			#6;
			if (run) bus_clk = ~bus_clk;
		end
	end
	always @(negedge bus_clk) begin
		if (cmd_oe) begin
			frame <= oe_prev ? {frame[134:0], cmd_line} : {135'h0, cmd_line};
			nbits <= oe_prev ? nbits + 1 : 1;
		end
		oe_prev <= cmd_oe;
	end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
	import crf_pkg::*;
	logic core_clk, rst_b, run, cmd_strobe, cmd_app, cmd_defined, vdd_ok, power_busy, block_busy;
	logic [5:0] cmd_index;
	logic [31:0] card_status, operating_conditions_register;
	logic [127:0] card_identity_register, card_specific_data_register;
	logic [15:0] relative_card_address;
	logic bus_clk, cmd_out, cmd_oe, dat0_out, dat0_oe, resp_pending;
	crf_state_t card_state;
	logic [135:0] frame;
	int nbits, num_errors, checks, seed, cyc, i;
	crf_formatter i_crf_formatter (.core_clk, .rst_b, .bus_clk, .cmd_strobe, .cmd_index, .cmd_app,
		.cmd_defined, .vdd_ok, .power_busy, .block_busy, .card_status, .card_identity_register,
		.card_specific_data_register, .operating_conditions_register, .relative_card_address,
		.cmd_out, .cmd_oe, .dat0_out, .dat0_oe, .card_state, .resp_pending);
	crf_host_model i_crf_host_model (.run, .cmd_out, .cmd_oe, .bus_clk, .frame, .nbits);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic results();
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input logic [135:0] got, input logic [135:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [6:0] seven_bit_checksum(input logic [39:0] d);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int k = 39; k >= 0; k--) begin
			fb = d[k] ^ c[6];
			c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
		end
		return c;
	endfunction
	function automatic logic [135:0] short_f(input logic [5:0] idx, input logic [31:0] arg, input logic crc_on);
		logic [39:0] h;
		h = {2'b00, idx, arg};
		return {88'h0, h, crc_on ? seven_bit_checksum(h) : 7'h7F, 1'b1};
	endfunction
	function automatic logic [135:0] long_f(input logic [127:0] r);
		return {2'b00, 6'h3F, r[127:1], 1'b1};
	endfunction
	task automatic rnd();
		card_status = $random(seed);
		operating_conditions_register = $random(seed);
		card_identity_register = {$random(seed), $random(seed), $random(seed), $random(seed)};
		card_specific_data_register = {$random(seed), $random(seed), $random(seed), $random(seed)};
		relative_card_address = 16'($random(seed));
	endtask
	task automatic send(input logic [5:0] idx, input logic app, input logic def, input logic [135:0] exp,
		input int len, input crf_state_t st);
		logic [135:0] f0;
		int n;
		f0 = frame;
		run = 1'b1;
		@(posedge core_clk);
		#1;
		cmd_strobe = 1'b1;
		cmd_index = idx;
		cmd_app = app;
		cmd_defined = def;
		@(posedge core_clk);
		#1;
		cmd_strobe = 1'b0;
		chk(card_state, st);
		chk(resp_pending, len != 0);
		if (len != 0) begin
			@(posedge core_clk);
			#1;
			cmd_strobe = 1'b1;
			cmd_index = 6'h0D;
			cmd_app = 1'b0;
			cmd_defined = 1'b1;
			@(posedge core_clk);
			#1;
			cmd_strobe = 1'b0;
			chk(card_state, st);
			chk(resp_pending, 1'b1);
		end
		n = 0;
		while (resp_pending === 1'b1 && n < 3000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(resp_pending, 1'b0);
		if (len == 0) begin
			repeat (200) @(posedge core_clk);
			#1;
			chk(frame, f0);
		end else begin
			chk(frame, exp);
			chk(nbits, len);
		end
		chk(cmd_oe, 1'b0);
		run = 1'b0;
		rnd();
	endtask
	task automatic do_reset();
		run = 1'b1;
		rst_b = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		chk({card_state, resp_pending, cmd_oe, cmd_out, dat0_oe}, {CRF_IDLE, 4'b0010});
	endtask
	initial begin
		seed = 76;
		{cmd_strobe, cmd_app, cmd_defined, block_busy, power_busy, cmd_index} = '0;
		vdd_ok = 1'b1;
		rnd();
		do_reset();
		send(6'h02, 1'b0, 1'b0, '0, 0, CRF_IDLE);
		power_busy = 1'b1;
		send(6'h29, 1'b1, 1'b0, short_f(6'h3F, operating_conditions_register, 1'b0), 48, CRF_IDLE);
		power_busy = 1'b0;
		send(6'h29, 1'b1, 1'b0, short_f(6'h3F, operating_conditions_register, 1'b0), 48, CRF_READY);
		send(6'h03, 1'b0, 1'b0, '0, 0, CRF_READY);
		send(6'h02, 1'b0, 1'b0, long_f(card_identity_register), 136, CRF_IDENT);
		send(6'h03, 1'b0, 1'b0, short_f(6'h03, {relative_card_address, card_status[23], card_status[22],
			card_status[19], card_status[12:0]}, 1'b1), 48, CRF_STBY);
		send(6'h09, 1'b0, 1'b0, long_f(card_specific_data_register), 136, CRF_STBY);
		send(6'h0A, 1'b0, 1'b0, long_f(card_identity_register), 136, CRF_STBY);
		for (i = 0; i < 6; i++) begin
			cmd_index = 6'($random(seed));
			if (cmd_index inside {6'h02, 6'h03, 6'h09, 6'h0A}) cmd_index = 6'h0D;
			send(cmd_index, 1'b0, 1'b1, short_f(cmd_index, card_status, 1'b1), 48, CRF_STBY);
		end
		run = 1'b1;
		block_busy = 1'b1;
		repeat (20) @(posedge core_clk);
		chk({dat0_oe, dat0_out}, 2'b10);
		block_busy = 1'b0;
		repeat (20) @(posedge core_clk);
		#1;
		chk(dat0_oe, 1'b0);
		do_reset();
		vdd_ok = 1'b0;
		send(6'h29, 1'b1, 1'b0, short_f(6'h3F, operating_conditions_register, 1'b0), 48, CRF_INACTIVE);
		results();
	end
endmodule
